// ==== core/nvb_bus.sv ====
// Byte-wide nonvolatile SRAM bus controller with decoded selects
// Function
// R1: Drive a separate 15-bit address bus for every SRAM access.
// R2: No address bit 15 on the bus; upper range selected by chip enables.
// R3: Support 8k, 32k and 128k SRAM parts with no glue logic.
// R4: With 8k parts the board leaves address bits 13 and 14 open.
// R5: In 128k mode second and third selects carry address bits 16 and 15.
// R6: Eight-bit two-way data bus, driven on writes, sampled on reads.
// R7: Data bus may be shared by SRAM and an optional peripheral.
// R8: One write enable, gated by memory map and program/data partition.
// R9: Never assert write enable inside program space.
// R10: First select is the primary select of one SRAM.
// R11: Reset is active high; a 1 resets the block.
// R12: Reset pad pulled down, so an open pin keeps the block running.
// R13: Primary select held high while supply is below backup voltage.
// R14: One select at most per access; all selects high when idle or reset.
// R15: Reads release the data bus and latch the byte at access end.
`include "nvb_regs.svh"

module nvb_bus (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [1:0]        sram_size,
   input  wire logic [4:0]        prog_blocks,
   input  wire logic              supply_low_async,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic              req_periph,
   input  wire logic [16:0]       req_addr,
   input  wire logic [7:0]        req_wdata,
   output logic                   resp_done,
   output logic                   resp_err,
   output logic [7:0]             resp_rdata,
   output logic [14:0]            byte_bus_address,
   output logic [7:0]             byte_bus_data_drv,
   output logic                   byte_bus_data_oe,
   input  wire logic [7:0]        byte_bus_data_rcv,
   output logic                   primary_sram_select_n,
   output logic                   second_select_or_addr_bit16,
   output logic                   third_select_or_addr_bit15,
   output logic                   fourth_select_n,
   output logic                   write_enable_n
);

   typedef struct packed {
      nvb_pkg::nvb_state_t st;
      logic [3:0]          cnt;
      logic                big;
      logic                wr;
      logic [14:0]         addr;
      logic [3:0]          pins;
      logic                we_n;
      logic [7:0]          dout;
      logic                doe;
      logic [7:0]          rdata;
      logic                done;
      logic                err;
   } nvb_state_s_t;

   nvb_state_s_t s_q;
   nvb_state_s_t s_d;

   logic       supply_low;
   logic [7:0] data_in;
   logic       dec_ok;
   logic       prot;
   logic [1:0] slot;
   logic [3:0] sel_pins;
   logic [3:0] idle_pins;

   nvb_sync #(.WIDTH(1)) u_sync_supply (
      .clk      (clk),
      .reset    (reset),
      .raw_level  (supply_low_async),
      .sync_level (supply_low)
   );

   // Read data comes from pins, so it is synchronised like any pin input
   nvb_sync #(.WIDTH(8)) u_sync_data (
      .clk      (clk),
      .reset    (reset),
      .raw_level  (byte_bus_data_rcv),
      .sync_level (data_in)
   );

   // Decode the linear 17-bit address into a select slot
   always_comb begin
      dec_ok   = 1'b1;
      slot     = `NVB_FIRST_SLOT;
      sel_pins = `NVB_SEL_IDLE;
      prot     = (req_addr[`NVB_BLK_HI:`NVB_BLK_LO] < prog_blocks); // [R9]
      case (nvb_pkg::nvb_size_t'(sram_size))
         nvb_pkg::NVB_SIZE_8K: begin
            dec_ok = (req_addr[`NVB_MEM_BIT16:`NVB_MEM_BIT15] == `NVB_FIRST_SLOT)
                     && !req_periph; // [R3] [R4]
            slot   = req_addr[`NVB_A14:`NVB_A13];
            sel_pins = ~(`NVB_SEL_ONE << slot); // [R14]
         end
         nvb_pkg::NVB_SIZE_32K: begin
            dec_ok   = !req_periph; // [R3]
            slot     = req_addr[`NVB_MEM_BIT16:`NVB_MEM_BIT15];
            sel_pins = ~(`NVB_SEL_ONE << slot); // [R2] [R14]
         end
         nvb_pkg::NVB_SIZE_128K: begin
            slot     = req_periph ? `NVB_PERIPH_SLOT : `NVB_FIRST_SLOT; // [R7]
            sel_pins = `NVB_SEL_IDLE;
            sel_pins[`NVB_PIN_HI_ADDR] = req_addr[`NVB_MEM_BIT16]; // [R5]
            sel_pins[`NVB_PIN_LO_ADDR] = req_addr[`NVB_MEM_BIT15]; // [R5]
            if (req_periph) begin
               sel_pins[`NVB_PIN_SEL4] = 1'b0; // [R7]
            end else begin
               sel_pins[`NVB_PIN_SEL1] = 1'b0; // [R10]
            end
         end
         default: begin
            dec_ok = 1'b0;
         end
      endcase
      // Peripherals are never program space, so they stay writable
      if (req_periph) begin
         prot = 1'b0;
      end
   end

   // Address bits stay on the pins only while 128k mode is still chosen;
   // otherwise these pins are selects again and must park high
   always_comb begin
      idle_pins = `NVB_SEL_IDLE; // [R14]
      if (s_q.big && (nvb_pkg::nvb_size_t'(sram_size) == nvb_pkg::NVB_SIZE_128K)) begin
         idle_pins[`NVB_PIN_HI_ADDR] = s_q.pins[`NVB_PIN_HI_ADDR]; // [R5]
         idle_pins[`NVB_PIN_LO_ADDR] = s_q.pins[`NVB_PIN_LO_ADDR]; // [R5]
      end
   end

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.err  = 1'b0;
      case (s_q.st)
         nvb_pkg::NVB_ST_IDLE: begin
            s_d.pins = idle_pins;
            s_d.we_n = 1'b1;
            s_d.doe  = 1'b0;
            if (req_valid && !supply_low) begin
               if (!dec_ok || (req_write && prot)) begin
                  // Refused with no bus cycle, so program space is untouched
                  s_d.err  = 1'b1; // [R9]
                  s_d.done = 1'b1;
               end else begin
                  s_d.st   = nvb_pkg::NVB_ST_SETUP;
                  s_d.big  = (nvb_pkg::nvb_size_t'(sram_size) == nvb_pkg::NVB_SIZE_128K);
                  s_d.wr   = req_write;
                  s_d.addr = req_addr[`NVB_A14:0]; // [R1] [R2]
                  s_d.pins = sel_pins; // [R14]
                  s_d.dout = req_wdata;
                  s_d.doe  = req_write; // [R6] [R15]
               end
            end
         end
         nvb_pkg::NVB_ST_SETUP: begin
            // Address and select settle one cycle before the strobe
            s_d.we_n = !s_q.wr; // [R8]
            s_d.cnt  = 4'(`NVB_STROBE_CYC);
            s_d.st   = nvb_pkg::NVB_ST_STROBE;
         end
         nvb_pkg::NVB_ST_STROBE: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               s_d.we_n = 1'b1; // [R8]
               s_d.cnt  = `NVB_HOLD_CYC;
               s_d.st   = nvb_pkg::NVB_ST_HOLD;
            end
         end
         nvb_pkg::NVB_ST_HOLD: begin
            // Select held through the synchroniser delay of the read data
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               if (!s_q.wr) begin
                  s_d.rdata = data_in; // [R15]
               end
               s_d.pins = idle_pins; // [R14]
               s_d.doe  = 1'b0;
               s_d.done = 1'b1;
               s_d.st   = nvb_pkg::NVB_ST_IDLE;
            end
         end
         default: begin
            s_d.st = nvb_pkg::NVB_ST_IDLE;
         end
      endcase
      // Supply collapse aborts any access and parks every select high
      if (supply_low) begin
         if (s_q.st != nvb_pkg::NVB_ST_IDLE) begin
            s_d.done = 1'b1;
            s_d.err  = 1'b1;
         end
         s_d.st   = nvb_pkg::NVB_ST_IDLE;
         s_d.pins = idle_pins;
         s_d.pins[`NVB_PIN_SEL1] = 1'b1; // [R13]
         s_d.we_n = 1'b1;
         s_d.doe  = 1'b0;
      end
   end

   // Only a logic 1 resets; the pad pull-down keeps an open pin at 0
   always_ff @(posedge clk) begin
      if (reset) begin // [R11] [R12]
         s_q      <= '0;
         s_q.st   <= nvb_pkg::NVB_ST_IDLE;
         s_q.pins <= `NVB_SEL_IDLE; // [R14]
         s_q.we_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign req_ready                   = (s_q.st == nvb_pkg::NVB_ST_IDLE) && !supply_low;
   assign resp_done                   = s_q.done;
   assign resp_err                    = s_q.err;
   assign resp_rdata                  = s_q.rdata;
   assign byte_bus_address            = s_q.addr; // [R1]
   assign byte_bus_data_drv           = s_q.dout; // [R6] [R7]
   assign byte_bus_data_oe            = s_q.doe;
   assign primary_sram_select_n       = s_q.pins[`NVB_PIN_SEL1]; // [R10]
   assign second_select_or_addr_bit16 = s_q.pins[`NVB_PIN_HI_ADDR];
   assign third_select_or_addr_bit15  = s_q.pins[`NVB_PIN_LO_ADDR];
   assign fourth_select_n             = s_q.pins[`NVB_PIN_SEL4];
   assign write_enable_n              = s_q.we_n; // [R8] [R9]

endmodule

// ==== core/nvb_regs.svh ====
// Named constants for the byte-wide nonvolatile SRAM bus block
`ifndef NVB_REGS_SVH
`define NVB_REGS_SVH

`define NVB_CLK_PERIOD_NS  8
`define NVB_STROBE_NS      70
`define NVB_STROBE_CYC     ((`NVB_STROBE_NS + `NVB_CLK_PERIOD_NS - 1) / `NVB_CLK_PERIOD_NS)
`define NVB_HOLD_CYC       4'h2
`define NVB_SEL_IDLE       4'hf
`define NVB_SEL_ONE        4'h1
`define NVB_MEM_BIT16      16
`define NVB_MEM_BIT15      15
`define NVB_A14            14
`define NVB_A13            13
`define NVB_BLK_HI         16
`define NVB_BLK_LO         12
`define NVB_PIN_SEL1       0
`define NVB_PIN_HI_ADDR    1
`define NVB_PIN_LO_ADDR    2
`define NVB_PIN_SEL4       3
`define NVB_PERIPH_SLOT    2'h3
`define NVB_FIRST_SLOT     2'h0

`endif

// ==== core/nvb_pkg.sv ====
// Types shared by the byte-wide nonvolatile SRAM bus block
package nvb_pkg;

   typedef enum logic [1:0] {
      NVB_SIZE_8K   = 2'h0,
      NVB_SIZE_32K  = 2'h1,
      NVB_SIZE_128K = 2'h2,
      NVB_SIZE_RSVD = 2'h3
   } nvb_size_t;

   typedef enum logic [1:0] {
      NVB_ST_IDLE   = 2'h0,
      NVB_ST_SETUP  = 2'h1,
      NVB_ST_STROBE = 2'h2,
      NVB_ST_HOLD   = 2'h3
   } nvb_state_t;

endpackage

// ==== core/nvb_sync.sv ====
// Two-flop synchroniser for pin inputs
module nvb_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] raw_level,
   output logic      [WIDTH-1:0] sync_level
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } nvb_sync_state_t;

   nvb_sync_state_t s_q;
   nvb_sync_state_t s_d;

   always_comb begin
      s_d.meta   = raw_level;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_level = s_q.stable;

endmodule

// ==== bench/nvb_bus_asserts.sv ====
// Port-level checker for the byte-wide SRAM bus block
module nvb_bus_asserts (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        supply_low_async,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        resp_done,
   input wire logic        resp_err,
   input wire logic [14:0] byte_bus_address,
   input wire logic        byte_bus_data_oe,
   input wire logic        primary_sram_select_n,
   input wire logic        fourth_select_n,
   input wire logic        write_enable_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_we_drive: assert property (!write_enable_n |-> byte_bus_data_oe)
      else $error("write enable without data drive");
   // A supply abort cuts the strobe short on purpose
   chk_we_width: assert property (disable iff (reset || supply_low_async)
      $fell(write_enable_n) |->
      !write_enable_n [*8] ##1 !write_enable_n ##1 write_enable_n)
      else $error("write strobe length wrong");
   chk_we_done: assert property (disable iff (reset || supply_low_async)
      $fell(write_enable_n) |-> ##11 resp_done)
      else $error("write not finished on time");
   chk_sel_idle: assert property (req_ready |-> primary_sram_select_n && fourth_select_n)
      else $error("select low while idle");
   chk_one_sel: assert property (primary_sram_select_n || fourth_select_n)
      else $error("two selects low");
   chk_err_done: assert property (resp_err |-> resp_done)
      else $error("error without done");
   chk_oe_busy: assert property (byte_bus_data_oe |-> !req_ready)
      else $error("data driven while idle");
   chk_sup_sel: assert property (supply_low_async [*4] |-> primary_sram_select_n)
      else $error("primary select low on low supply");
   chk_sup_ready: assert property (supply_low_async [*3] |-> !req_ready)
      else $error("ready on low supply");
   // A request taken while done is high may move the address at once
   chk_addr_hold: assert property (resp_done && !(req_valid && req_ready) |=>
      $stable(byte_bus_address))
      else $error("address moved after access");
   // Reset itself is the antecedent, so the default disable is lifted
   chk_rst_idle: assert property (disable iff (1'b0) reset |=> primary_sram_select_n &&
      fourth_select_n && write_enable_n && !resp_done)
      else $error("bus not idle after reset");
   cov_ok: cover property (resp_done && !resp_err);
   cov_err: cover property (resp_done && resp_err);
   cov_wr: cover property ($fell(write_enable_n));
endmodule
bind nvb_bus nvb_bus_asserts chk_u (.*);

// ==== bench/nvb_sram_model.sv ====
// Behavioural SRAM bank on the far side of the byte-wide bus
module nvb_sram_model (
   input  wire logic [1:0]  size,
   input  wire logic [14:0] addr,
   input  wire logic [3:0]  sel_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  wdat,
   output logic      [7:0]  rdat
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:131071];
   logic [16:0] key;
   logic [1:0]  idx;
   logic        sel;
   logic        rd;
   always_comb begin
      idx = !sel_n[0] ? 2'h0 : !sel_n[1] ? 2'h1 : !sel_n[2] ? 2'h2 : 2'h3;
      if (size == 2'h2) key = {sel_n[1], sel_n[2], addr};
      else if (size == 2'h0) key = {2'h0, idx, addr[12:0]};
      else key = {idx, addr};
      // In 128k mode the fourth select is a peripheral, not this memory
      sel = (size == 2'h2) ? !sel_n[0] : !(&sel_n);
      rd = we_n && sel;
   end
   // SRAM latches at the end of the strobe, only while selected
   always @(posedge we_n) if (sel) mem[key] <= wdat;
   // Released lines show the inverse so stale data never matches
   assign rdat = rd ? mem[key] : ~mem[key];
endmodule

// ==== bench/test_nvb_bus.sv ====
// Self-checking bench for the byte-wide SRAM bus block
module test_nvb_bus;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [1:0]  size = 2'h1;
   logic [4:0]  prog = 5'h00;
   logic        sup = 1'b0;
   logic        rv = 1'b0;
   logic        rw = 1'b0;
   logic        rp = 1'b0;
   logic [16:0] ra = 17'h00000;
   logic [7:0]  wd = 8'h00;
   logic        ready, done, err, oe, s1, s2, s3, s4, we_n;
   logic [7:0]  rdata, dout, din;
   logic [14:0] baddr;
   int          n_errors = 0;
   int          checked = 0;
   int          cyc = 0;
   always #4 clk = ~clk;
   nvb_bus dut_u (.clk(clk), .reset(reset), .sram_size(size), .prog_blocks(prog),
      .supply_low_async(sup), .req_valid(rv), .req_ready(ready), .req_write(rw),
      .req_periph(rp), .req_addr(ra), .req_wdata(wd), .resp_done(done), .resp_err(err),
      .resp_rdata(rdata), .byte_bus_address(baddr), .byte_bus_data_drv(dout),
      .byte_bus_data_oe(oe), .byte_bus_data_rcv(din), .primary_sram_select_n(s1),
      .second_select_or_addr_bit16(s2), .third_select_or_addr_bit15(s3),
      .fourth_select_n(s4), .write_enable_n(we_n));
   nvb_sram_model mem_u (.size(size), .addr(baddr), .sel_n({s4, s3, s2, s1}),
      .we_n(we_n), .wdat(dout), .rdat(din));
   task automatic close_out();
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(string what, logic [16:0] exp, logic [16:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One access; read data is judged only on good reads
   task automatic acc(logic w, logic [16:0] a, logic [7:0] d, logic e, logic [7:0] r);
      @(posedge clk);
      rw <= w;
      ra <= a;
      wd <= d;
      rv <= 1'b1;
      do @(negedge clk); while (ready !== 1'b1);
      @(posedge clk);
      rv <= 1'b0;
      repeat (20) begin
         @(negedge clk);
         if (done === 1'b1) break;
      end
      cmp("done", 17'h1, done);
      cmp("err", e, err);
      if (!w && !e) cmp("rdata", r, rdata);
   endtask
   task automatic t_reset();
      @(negedge clk);
      cmp("idle pins", 17'h0003e, {s1, s2, s3, s4, we_n, oe});
   endtask
   task automatic t_rw();
      acc(1'b1, 17'h08000, 8'ha5, 1'b0, 8'h00);
      cmp("address", 17'h0000, baddr);
      acc(1'b1, 17'h00010, 8'h5a, 1'b0, 8'h00);
      acc(1'b0, 17'h08000, 8'h00, 1'b0, 8'ha5);
      acc(1'b0, 17'h00010, 8'h00, 1'b0, 8'h5a);
   endtask
   task automatic t_prog();
      @(posedge clk) prog <= 5'h02;
      acc(1'b1, 17'h00010, 8'hff, 1'b1, 8'h00);
      acc(1'b0, 17'h00010, 8'h00, 1'b0, 8'h5a);
      @(posedge clk) prog <= 5'h00;
   endtask
   task automatic t_size();
      @(posedge clk) rp <= 1'b1;
      acc(1'b0, 17'h00010, 8'h00, 1'b1, 8'h00);
      @(posedge clk) rp <= 1'b0;
      @(posedge clk) size <= 2'h0;
      acc(1'b0, 17'h08000, 8'h00, 1'b1, 8'h00);
      acc(1'b1, 17'h06001, 8'h77, 1'b0, 8'h00);
      acc(1'b0, 17'h06001, 8'h00, 1'b0, 8'h77);
      @(posedge clk) size <= 2'h3;
      acc(1'b0, 17'h00000, 8'h00, 1'b1, 8'h00);
   endtask
   // Upper pins split 1/0 so a parked-high pair cannot pass
   task automatic t_big();
      @(posedge clk) size <= 2'h2;
      acc(1'b1, 17'h10003, 8'h3c, 1'b0, 8'h00);
      cmp("upper pins", 17'h2, {s2, s3});
      cmp("address", 17'h0003, baddr);
      @(posedge clk) rp <= 1'b1;
      acc(1'b1, 17'h10003, 8'hc3, 1'b0, 8'h00);
      @(posedge clk) rp <= 1'b0;
      acc(1'b0, 17'h10003, 8'h00, 1'b0, 8'h3c);
      @(posedge clk) size <= 2'h1;
   endtask
   task automatic t_supply();
      fork
         acc(1'b0, 17'h08000, 8'h00, 1'b1, 8'h00);
         begin
            repeat (5) @(posedge clk);
            sup <= 1'b1;
         end
      join
      cmp("primary select", 17'h1, s1);
      @(posedge clk) sup <= 1'b0;
      acc(1'b0, 17'h08000, 8'h00, 1'b0, 8'ha5);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_rw();
      t_prog();
      t_size();
      t_big();
      t_supply();
      close_out();
   end
endmodule
